// ===== tpd_pkg.sv
// What this block does
// - Mode 11 selects dithered 8+8-bit counter
// - Selector 100 routes dithered waveform to pin
// - Trigger 00 counts on every divided tick
// - Dithered: low byte equals duty, go high
// - Dithered: period match drops, flags, restarts
// - Interrupt only while overflow enable is set
// - Trim makes high width N+1 or N
// - Long periods placed by trim bit weight
// - Trim bits superpose by OR, count equals trim
// - Frequency tick over period+1, duty adds trim/256
// - Enable starts timer, clear restarts counter and zeroes output
// - Per-pin polarity inverts or passes waveform
// - Mode 01 selects 17-bit up/down counter
// - Selector 101 routes dual-slope waveform to pin
// - Up slope: first compare high, second low
// - Period match reverses counter to down
// - Down slope: second compare high, first low
// - Zero on down slope overflows, flags, counts up
// - Polarity 0 inverts, 1 in phase
// Purpose: Constants and types for the dithered and dual-slope PWM timer
// Assumes: APB slave with 32-bit data, one clock
// Notes:   All offsets are byte addresses
package tpd_pkg;
  localparam logic [11:0] CTRL_OFS  = 12'h000;
  localparam logic [11:0] PER_OFS   = 12'h004;
  localparam logic [11:0] CMP1_OFS  = 12'h008;
  localparam logic [11:0] CMP2_OFS  = 12'h00c;
  localparam logic [11:0] PIN_OFS   = 12'h010;
  localparam logic [11:0] STAT_OFS  = 12'h014;
  localparam logic [11:0] CNT_OFS   = 12'h018;
  localparam logic [1:0] MODE_DITHER = 2'b11;
  localparam logic [1:0] MODE_DUAL   = 2'b01;
  localparam logic [1:0] TRIG_ALWAYS = 2'b00;
  localparam logic [2:0] SEL_DITHER  = 3'b100;
  localparam logic [2:0] SEL_DUAL    = 3'b101;
  // Control register fields
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_TRIG_LO = 3;
  localparam int CTRL_SRC_LO  = 5;
  localparam int CTRL_DIV_LO  = 7;
  localparam int CTRL_IE_BIT  = 9;
  localparam int CTRL_CLR_BIT = 10;
  // Pin register fields, pin 0 in [5:0], pin 1 in [13:8]
  localparam int PIN_SEL_LO = 0;
  localparam int PIN_POL    = 3;
  localparam int PIN_PWM    = 4;
  localparam int PIN_OE     = 5;
  localparam int PIN1_LO    = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PIN_RST  = 32'h0000_0000;

  typedef struct packed {
    logic       out_en;
    logic       pwm_mode;
    logic       polarity;
    logic [2:0] sel;
  } tpd_pin_cfg_t;
endpackage

// ===== tpd_top.sv
// Purpose: PWM timer with dithered 8+8-bit and dual-slope 17-bit modes
// Assumes: Synchronous active-low reset, external clock source ticks
// Notes:   Divided tick = chosen source, further divided by 1,2,4,8
`timescale 1ns/1ps
module tpd_top (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  src_tick,
  output logic [1:0]       pwm_pin_out,
  output logic [1:0]       pwm_pin_oe,
  output logic             overflow_irq
);
  // ====================================================
  // Registers
  logic [31:0] ctrl_q;
  logic [15:0] period_compare_q;
  logic [15:0] first_compare_q;
  logic [15:0] second_compare_q;
  logic [13:0] pin_q;
  logic        overflow_flag_q;
  logic [15:0] timer_counter_q;
  logic        down_q;
  logic        wave_q;
  logic [7:0]  frame_q;
  logic        run_q;
  logic [2:0]  pre_q;
  logic        dith_out_q;
  logic        dual_out_q;
  logic [31:0] prdata_q;

  logic        timer_enable_bit;
  logic [1:0]  timer_mode_field;
  logic [1:0]  count_trigger_select;
  logic [1:0]  clock_source_select;
  logic [1:0]  clock_divider_select;
  logic        overflow_irq_enable;
  logic        divided_timer_clock;
  logic        src_sel;
  logic        cnt_tick;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        ovf_evt;
  logic        long_period;
  logic [7:0]  timer_counter_low;
  logic [7:0]  period_compare_low;
  logic [7:0]  duty_compare_low;
  logic [7:0]  duty_fine_trim;
  logic [8:0]  set_point;
  logic [31:0] rd_mux;

  assign timer_enable_bit     = ctrl_q[tpd_pkg::CTRL_EN_BIT];
  assign timer_mode_field     = ctrl_q[tpd_pkg::CTRL_MODE_LO +: 2];
  assign count_trigger_select = ctrl_q[tpd_pkg::CTRL_TRIG_LO +: 2];
  assign clock_source_select  = ctrl_q[tpd_pkg::CTRL_SRC_LO +: 2];
  assign clock_divider_select = ctrl_q[tpd_pkg::CTRL_DIV_LO +: 2];
  assign overflow_irq_enable  = ctrl_q[tpd_pkg::CTRL_IE_BIT];
  assign timer_counter_low    = timer_counter_q[7:0];
  assign period_compare_low   = period_compare_q[7:0];
  assign duty_compare_low     = first_compare_q[7:0];
  assign duty_fine_trim       = second_compare_q[7:0];

  // Pin config unpack
  function automatic tpd_pkg::tpd_pin_cfg_t pin_cfg(input logic [5:0] f);
    pin_cfg = tpd_pkg::tpd_pin_cfg_t'({f[tpd_pkg::PIN_OE], f[tpd_pkg::PIN_PWM],
                                       f[tpd_pkg::PIN_POL], f[2:0]});
  endfunction

  // Trim spreading: overflow k is long if trim bit 7-b is set, where b
  // is the lowest set bit of k
  function automatic logic trim_long(input logic [7:0] trim, input logic [7:0] k);
    logic r;
    r = 1'b0;
    for (int b = 0; b < 8; b++) begin
      if (k[b] && (k & ((8'h01 << b) - 8'h01)) == 8'h00) begin
        r = trim[7 - b];
      end
    end
    trim_long = r;
  endfunction

  // ====================================================
  // APB slave, zero wait states
  assign pready  = 1'b1;
  assign addr_ok = (paddr == tpd_pkg::CTRL_OFS) || (paddr == tpd_pkg::PER_OFS) ||
                   (paddr == tpd_pkg::CMP1_OFS) || (paddr == tpd_pkg::CMP2_OFS) ||
                   (paddr == tpd_pkg::PIN_OFS)  || (paddr == tpd_pkg::STAT_OFS) ||
                   (paddr == tpd_pkg::CNT_OFS);
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~penable & ~pwrite;
  assign prdata  = prdata_q;

  // Read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      tpd_pkg::CTRL_OFS: rd_mux = {21'h0, ctrl_q[10:0]} & 32'h0000_03ff;
      tpd_pkg::PER_OFS:  rd_mux = {16'h0, period_compare_q};
      tpd_pkg::CMP1_OFS: rd_mux = {16'h0, first_compare_q};
      tpd_pkg::CMP2_OFS: rd_mux = {16'h0, second_compare_q};
      tpd_pkg::PIN_OFS:  rd_mux = {18'h0, pin_q};
      tpd_pkg::STAT_OFS: rd_mux = {29'h0, dual_out_q, dith_out_q, overflow_flag_q};
      tpd_pkg::CNT_OFS:  rd_mux = {15'h0, down_q, timer_counter_q};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data captured in setup, held through access
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata_q <= rd_mux;
    end
  end

  // Config registers; clear bit self-clears
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_q           <= tpd_pkg::CTRL_RST;
      period_compare_q <= 16'h0000;
      first_compare_q  <= 16'h0000;
      second_compare_q <= 16'h0000;
      pin_q            <= 14'h0000;
    end else begin
      ctrl_q[tpd_pkg::CTRL_CLR_BIT] <= 1'b0;
      if (wr_en) begin
        unique case (paddr)
          tpd_pkg::CTRL_OFS: ctrl_q <= {21'h0, pwdata[10:0]};
          tpd_pkg::PER_OFS:  period_compare_q <= pwdata[15:0];
          tpd_pkg::CMP1_OFS: first_compare_q  <= pwdata[15:0];
          tpd_pkg::CMP2_OFS: second_compare_q <= pwdata[15:0];
          tpd_pkg::PIN_OFS:  pin_q <= pwdata[13:0];
          default: ;
        endcase
      end
    end
  end

  // ====================================================
  // Divided timer clock
  always_comb begin
    unique case (clock_source_select)
      2'b00:   src_sel = 1'b1;
      2'b01:   src_sel = src_tick[0];
      2'b10:   src_sel = src_tick[1];
      default: src_sel = src_tick[2];
    endcase
  end

  // Prescaler
  always_ff @(posedge core_clk) begin
    if (!rst_n || !timer_enable_bit) begin
      pre_q <= 3'h0;
    end else if (src_sel) begin
      pre_q <= pre_q + 3'h1;
    end
  end

  always_comb begin
    unique case (clock_divider_select)
      2'b00:   divided_timer_clock = src_sel;
      2'b01:   divided_timer_clock = src_sel & pre_q[0];
      2'b10:   divided_timer_clock = src_sel & (pre_q[1:0] == 2'b11);
      default: divided_timer_clock = src_sel & (pre_q == 3'b111);
    endcase
  end

  assign cnt_tick = run_q & divided_timer_clock &
                    (count_trigger_select == tpd_pkg::TRIG_ALWAYS);

  // ====================================================
  // Counter, direction and dither frame
  assign long_period = trim_long(duty_fine_trim, frame_q);
  // Registered wave switches one count early so high lasts period+1-duty;
  // long periods start one count earlier still
  assign set_point = {1'b0, duty_compare_low} - 9'h001 - {8'h00, long_period};

  always_comb begin
    ovf_evt = 1'b0;
    if (cnt_tick && timer_mode_field == tpd_pkg::MODE_DITHER) begin
      ovf_evt = (timer_counter_low == period_compare_low);
    end else if (cnt_tick && timer_mode_field == tpd_pkg::MODE_DUAL) begin
      ovf_evt = down_q && (timer_counter_q == 16'h0001);
    end
  end

  // Counting starts one cycle after enable; a clear keeps it running
  always_ff @(posedge core_clk) begin
    if (!rst_n || !timer_enable_bit) begin
      run_q <= 1'b0;
    end else begin
      run_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || !timer_enable_bit || ctrl_q[tpd_pkg::CTRL_CLR_BIT]) begin
      timer_counter_q <= 16'h0000;
      down_q          <= 1'b0;
      frame_q         <= 8'h00;
    end else if (cnt_tick) begin
      unique case (timer_mode_field)
        tpd_pkg::MODE_DITHER: begin
          if (ovf_evt) begin
            timer_counter_q <= 16'h0000;
            frame_q         <= frame_q + 8'h01;
          end else begin
            timer_counter_q <= {8'h00, timer_counter_low + 8'h01};
          end
        end
        tpd_pkg::MODE_DUAL: begin
          if (!down_q && timer_counter_q == period_compare_q) begin
            down_q          <= 1'b1;
            timer_counter_q <= timer_counter_q - 16'h0001;
          end else if (down_q && timer_counter_q == 16'h0001) begin
            down_q          <= 1'b0;
            timer_counter_q <= 16'h0000;
          end else if (down_q) begin
            timer_counter_q <= timer_counter_q - 16'h0001;
          end else begin
            timer_counter_q <= timer_counter_q + 16'h0001;
          end
        end
        default: timer_counter_q <= timer_counter_q + 16'h0001;
      endcase
    end
  end

  // ====================================================
  // Waveforms
  always_ff @(posedge core_clk) begin
    if (!rst_n || !timer_enable_bit || ctrl_q[tpd_pkg::CTRL_CLR_BIT]) begin
      dith_out_q <= 1'b0;
    end else if (cnt_tick && timer_mode_field == tpd_pkg::MODE_DITHER) begin
      if (timer_counter_low == period_compare_low) begin
        dith_out_q <= 1'b0;
      end else if ({1'b0, timer_counter_low} == set_point) begin
        dith_out_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || !timer_enable_bit || ctrl_q[tpd_pkg::CTRL_CLR_BIT]) begin
      dual_out_q <= 1'b0;
    end else if (cnt_tick && timer_mode_field == tpd_pkg::MODE_DUAL) begin
      if (!down_q) begin
        if (timer_counter_q == first_compare_q) begin
          dual_out_q <= 1'b1;
        end else if (timer_counter_q == second_compare_q) begin
          dual_out_q <= 1'b0;
        end
      end else begin
        if (timer_counter_q == second_compare_q) begin
          dual_out_q <= 1'b1;
        end else if (timer_counter_q == first_compare_q) begin
          dual_out_q <= 1'b0;
        end
      end
    end
  end

  // Overflow flag: set beats software clear (write 1 to clear)
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      overflow_flag_q <= 1'b0;
    end else if (ovf_evt) begin
      overflow_flag_q <= 1'b1;
    end else if (wr_en && paddr == tpd_pkg::STAT_OFS && pwdata[0]) begin
      overflow_flag_q <= 1'b0;
    end
  end

  assign overflow_irq = overflow_flag_q & overflow_irq_enable;

  // ====================================================
  // Pin routing
  always_comb begin
    tpd_pkg::tpd_pin_cfg_t c;
    logic w;
    c = '0;
    w = 1'b0;
    pwm_pin_out = 2'b00;
    pwm_pin_oe  = 2'b00;
    for (int p = 0; p < 2; p++) begin
      c = pin_cfg(pin_q[p*tpd_pkg::PIN1_LO +: 6]);
      unique case (c.sel)
        tpd_pkg::SEL_DITHER: w = dith_out_q;
        tpd_pkg::SEL_DUAL:   w = dual_out_q;
        default:             w = 1'b0;
      endcase
      w = w & timer_enable_bit;
      pwm_pin_out[p] = c.polarity ? w : ~w;
      pwm_pin_oe[p]  = c.pwm_mode & c.out_en;
    end
  end
endmodule // tpd_top

// ===== tpd_chk.sv
// Purpose: Port-level assertions for the PWM timer
// Assumes: Shadow copies of written fields track the registers
// Notes:   Bound to tpd_top at the foot of this file
`timescale 1ns/1ps
module tpd_chk (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [2:0]  src_tick,
  input wire logic [1:0]  pwm_pin_out,
  input wire logic [1:0]  pwm_pin_oe,
  input wire logic        overflow_irq
);
  logic       wr;
  logic [1:0] oe_q;
  logic [1:0] pol_q;
  logic       ie_q;
  logic       en_q;
  logic [1:0] off_q;
  assign wr = psel && penable && pwrite;
  // ==========================================
  // Shadows of written fields
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      oe_q  <= 2'h0;
      pol_q <= 2'h0;
      ie_q  <= 1'b0;
      en_q  <= 1'b0;
    end else if (wr && paddr == tpd_pkg::PIN_OFS) begin
      oe_q  <= {pwdata[13] & pwdata[12], pwdata[5] & pwdata[4]};
      pol_q <= {pwdata[11], pwdata[3]};
    end else if (wr && paddr == tpd_pkg::CTRL_OFS) begin
      ie_q <= pwdata[9];
      en_q <= pwdata[0];
    end
  end
  // Cycles spent disabled, saturating at three
  always_ff @(posedge core_clk) begin
    if (!rst_n || en_q) off_q <= 2'h0;
    else if (off_q != 2'h3) off_q <= off_q + 2'h1;
  end
  // ==========================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  unmapped_err_a: assert property (psel && penable && paddr > 12'h018 |-> pslverr)
    else $error("no error on unmapped access");
  unmapped_rd_a: assert property (psel && penable && !pwrite && paddr > 12'h018
    |-> prdata == 32'h0000_0000) else $error("unmapped read not zero");
  mapped_ok_a: assert property (psel && penable && paddr <= 12'h018 && paddr[1:0] == 2'b00
    |-> !pslverr) else $error("error on mapped access");
  pin_oe_a: assert property (pwm_pin_oe == oe_q)
    else $error("pin enable mismatch");
  irq_gate_a: assert property (overflow_irq |-> ie_q)
    else $error("irq without enable");
  stop_level_a: assert property (off_q == 2'h3 |-> pwm_pin_out == ~pol_q)
    else $error("stopped pin level wrong");
  stop_flag_a: assert property (off_q == 2'h3 && ie_q && !overflow_irq |=> !overflow_irq)
    else $error("flag set while stopped");
  flag_clr_a: assert property (off_q == 2'h3 && wr && paddr == tpd_pkg::STAT_OFS && pwdata[0]
    |=> !overflow_irq)
    else $error("flag not cleared");
endmodule // tpd_chk

bind tpd_top tpd_chk i_chk (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .src_tick(src_tick), .pwm_pin_out(pwm_pin_out), .pwm_pin_oe(pwm_pin_oe),
  .overflow_irq(overflow_irq));

// ===== tpd_top_bench.sv
// Purpose: Self-checking bench for the PWM timer
// Assumes: One-cycle APB access, registers at package offsets
// Notes:   Pin 1 runs the same waveform with inverted polarity
`timescale 1ns/1ps
module tpd_top_bench;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic [2:0]  src_tick = 3'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  pwm_pin_out;
  logic [1:0]  pwm_pin_oe;
  logic        overflow_irq;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cyc        = 0;
  tpd_top i_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_tick(src_tick), .pwm_pin_out(pwm_pin_out),
    .pwm_pin_oe(pwm_pin_oe), .overflow_irq(overflow_irq));
  // ==========================================
  // Clock, source ticks and hang guard
  initial forever #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    src_tick <= src_tick + 3'h1;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      end_sim();
    end
  end
  // ==========================================
  // Shared tasks
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer, held until pready is seen high
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, output logic [32:0] q);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    q = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    logic [32:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(logic [11:0] a, logic [32:0] exp);
    logic [32:0] q;
    apb(1'b0, a, 32'h0000_0000, q);
    chk("read", 32'(exp), q[31:0]);
    chk("slverr", 32'(exp[32]), 32'(q[32]));
  endtask
  // High and low width of pin 0, pin 1 checked as its inverse
  task automatic meas(output int hi, output int lo);
    int n;
    n = 0;
    hi = 0;
    lo = 0;
    while (pwm_pin_out[0] !== 1'b1 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    chk("pin1", 32'h0, 32'(pwm_pin_out[1]));
    while (pwm_pin_out[0] === 1'b1 && hi < 2000) begin
      @(negedge core_clk);
      hi++;
    end
    while (pwm_pin_out[0] !== 1'b1 && lo < 2000) begin
      @(negedge core_clk);
      lo++;
    end
  endtask
  function automatic int lng(int k, logic [7:0] t);
    for (int b = 0; b < 8; b++)
      if (k[b]) return int'(t[7-b]);
    return 0;
  endfunction
  // ==========================================
  // Scenarios
  // Dithered run: period 9, duty 4, one frame or a few periods
  task automatic dith(logic [31:0] ctl, logic [7:0] trim, int np, int sc);
    int hi, lo, nl, lg;
    nl = 0;
    wr(tpd_pkg::CMP2_OFS, {24'h0, trim});
    wr(tpd_pkg::CTRL_OFS, ctl);
    for (int k = 0; k < np; k++) begin
      meas(hi, lo);
      lg = lng(k, trim);
      nl += lg;
      chk("high", 32'((6 + lg) * sc), 32'(hi));
      // Low part ends at the next rise, one count early if that period is long
      chk("period", 32'((10 + lg - lng(k + 1, trim)) * sc), 32'(hi + lo));
    end
    if (np == 256) chk("longs", 32'(trim), 32'(nl));
    wr(tpd_pkg::CTRL_OFS, ctl & 32'hffff_fffe);
  endtask
  // Interrupt gating, flag clear and a stalled trigger
  task automatic irq_test();
    chk("irq", 32'h1, 32'(overflow_irq));
    wr(tpd_pkg::CTRL_OFS, 32'h0000_0006);
    chk("irq", 32'h0, 32'(overflow_irq));
    wr(tpd_pkg::CTRL_OFS, 32'h0000_0206);
    chk("irq", 32'h1, 32'(overflow_irq));
    wr(tpd_pkg::STAT_OFS, 32'h0000_0001);
    chk("irq", 32'h0, 32'(overflow_irq));
    wr(tpd_pkg::CTRL_OFS, 32'h0000_020f);
    repeat (40) @(negedge core_clk);
    chk("stall", 32'h0, 32'({overflow_irq, pwm_pin_out[0]}));
    wr(tpd_pkg::CTRL_OFS, 32'h0000_0206);
  endtask
  // Dual slope: period 20, first 5, second 12
  task automatic dual();
    int hi, lo;
    wr(tpd_pkg::PER_OFS, 32'h0000_0014);
    wr(tpd_pkg::CMP1_OFS, 32'h0000_0005);
    wr(tpd_pkg::CMP2_OFS, 32'h0000_000c);
    wr(tpd_pkg::PIN_OFS, 32'h0000_353d);
    wr(tpd_pkg::CTRL_OFS, 32'h0000_0203);
    for (int k = 0; k < 6; k++) begin
      meas(hi, lo);
      chk("dual high", 32'h7, 32'(hi));
      chk("dual low", (k % 2) ? 32'ha : 32'h10, 32'(lo));
    end
    chk("irq", 32'h1, 32'(overflow_irq));
    wr(tpd_pkg::CTRL_OFS, 32'h0000_0202);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    chk("reset pins", 32'h3, 32'({pwm_pin_oe, pwm_pin_out}));
    rd(tpd_pkg::CTRL_OFS, {1'b0, tpd_pkg::CTRL_RST});
    rd(tpd_pkg::PIN_OFS, {1'b0, tpd_pkg::PIN_RST});
    rd(12'h01c, 33'h1_0000_0000);
    wr(tpd_pkg::CTRL_OFS, 32'h0000_0400);
    rd(tpd_pkg::CTRL_OFS, 33'h0_0000_0000);
    wr(tpd_pkg::PER_OFS, 32'h0000_0009);
    wr(tpd_pkg::CMP1_OFS, 32'h0000_0004);
    wr(tpd_pkg::PIN_OFS, 32'h0000_343c);
    rd(tpd_pkg::PIN_OFS, 33'h0_0000_343c);
    chk("oe", 32'h3, 32'(pwm_pin_oe));
    dith(32'h0000_0207, 8'h80, 256, 1);
    dith(32'h0000_0207, 8'h40, 256, 1);
    dith(32'h0000_0207, 8'h01, 256, 1);
    dith(32'h0000_0207, 8'ha1, 256, 1);
    dith(32'h0000_0287, 8'h00, 8, 2);
    dith(32'h0000_0227, 8'h00, 8, 2);
    irq_test();
    dual();
    end_sim();
  end
endmodule // tpd_top_bench
